/* File: common/apmc_params.svh */
// register offsets, field positions and reset values of the power mask bank
`ifndef APMC_PARAMS_SVH
`define APMC_PARAMS_SVH
`define APMC_OFF_SPLIT 8'h05
`define APMC_OFF_PAGE 8'h11
`define APMC_OFF_P1_CORE 8'h20
`define APMC_OFF_P1_BUF 8'h21
`define APMC_OFF_P2_CORE 8'h23
`define APMC_OFF_P2_BUF 8'h24
`define APMC_OFF_PDCTL 8'h26
`define APMC_OFF_PEN 8'h55
`define APMC_PAGE_MASTER 8'h80
`define APMC_PAGE_CONV 8'h0f
`define APMC_BIT_CHOICE 5
`define APMC_BIT_PEN 0
`define APMC_BIT_SPLIT 0
`define APMC_BUFB_HI 7
`define APMC_BUFB_LO 6
`define APMC_BUFA_HI 5
`define APMC_BUFA_LO 4
`define APMC_RST_BYTE 8'h00
`define APMC_BUF_ON 2'b00
`define APMC_BUF_OFF 2'b11
`endif

/* File: common/apmc_pkg.sv */
// types shared by the power mask bank
package apmc_pkg;
  typedef logic [7:0] apmc_byte_t;
  typedef enum logic {apmc_page_master_t_unused} apmc_dummy_t;
  typedef enum {APMC_PG_NONE, APMC_PG_MASTER, APMC_PG_CONV} apmc_page_t;
endpackage

/* File: logic/apmc_buf_decode.sv */
// decodes one channel's two-bit buffer field into per-buffer sleep and per-core undriven flags
`timescale 1ns/1ps
`include "apmc_params.svh"
module apmc_buf_decode
  import apmc_pkg::*;
(
  input wire logic [1:0] code,
  input wire logic active,
  output logic [1:0] buf_sleep,
  output logic [3:0] core_undriven,
  output logic code_illegal
);
  // each bit of the field governs one buffer; 11 sleeps both
  always_comb
  begin
    buf_sleep = active ? code : 2'b00;
    // a sleeping buffer leaves its two cores without drive
    core_undriven = {{2{buf_sleep[1]}}, {2{buf_sleep[0]}}};
    code_illegal = (code != `APMC_BUF_ON) && (code != `APMC_BUF_OFF);
  end
endmodule

/* File: logic/apmc_regs.sv */
// register bank: channel split, analog page pointer, two power-down profiles
// Behaviour
// - split bit 0 writes both, else target
// - eight-bit page pointer, 80h master, 0Fh converter
// - profile one at master 20h and 21h
// - profile two at master 23h and 24h
// - profile choice is bit 5 of 26h
// - profile enable bit held at 55h
// - core byte upper nibble A, lower B
// - buffer field 00 active, 11 sleeps
// - buffer sleep removes drive from two cores
// - choice 0 profile one, 1 profile two
`timescale 1ns/1ps
`include "apmc_params.svh"
module apmc_regs
  import apmc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic channel_target_select,
  output logic [7:0] rdata,
  output logic [3:0] core_sleep_channel_a,
  output logic [3:0] core_sleep_channel_b,
  output logic [1:0] buffer_sleep_channel_a,
  output logic [1:0] buffer_sleep_channel_b,
  output logic [3:0] core_undriven_a,
  output logic [3:0] core_undriven_b,
  output logic buf_code_illegal,
  output logic write_to_a,
  output logic write_to_b
);
  // per channel copies: index 0 is channel A, 1 is channel B
  apmc_byte_t split_r;
  apmc_byte_t page_r;
  apmc_byte_t p1_core_r [2];
  apmc_byte_t p1_buf_r [2];
  apmc_byte_t p2_core_r [2];
  apmc_byte_t p2_buf_r [2];
  apmc_byte_t pdctl_r [2];
  apmc_byte_t pen_r [2];
  apmc_byte_t rdata_r;
  apmc_byte_t rd_nxt;
  apmc_page_t page;
  logic [1:0] ch_wr;
  logic sel_b;

  function automatic apmc_page_t page_of(input apmc_byte_t p);
    if (p == `APMC_PAGE_MASTER)
      page_of = APMC_PG_MASTER;
    else if (p == `APMC_PAGE_CONV)
      page_of = APMC_PG_CONV;
    else
      page_of = APMC_PG_NONE;
  endfunction

  assign page = page_of(page_r);
  assign sel_b = split_r[`APMC_BIT_SPLIT] & channel_target_select;

  // broadcast unless split, then only the targeted channel
  always_comb
  begin
    if (!split_r[`APMC_BIT_SPLIT])
      ch_wr = 2'b11;
    else if (channel_target_select)
      ch_wr = 2'b10;
    else
      ch_wr = 2'b01;
  end
  assign write_to_a = wr_stb & ch_wr[0];
  assign write_to_b = wr_stb & ch_wr[1];

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      split_r <= `APMC_RST_BYTE;
    else if (wr_stb && addr == `APMC_OFF_SPLIT)
      // reserved bits kept at zero even if software breaks the convention
      split_r <= {7'h00, wdata[`APMC_BIT_SPLIT]};
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      page_r <= `APMC_RST_BYTE;
    else if (wr_stb && addr == `APMC_OFF_PAGE)
      page_r <= wdata;
  end

  // master page registers, one set per channel
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ch
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          p1_core_r[g] <= `APMC_RST_BYTE;
          p1_buf_r[g] <= `APMC_RST_BYTE;
          p2_core_r[g] <= `APMC_RST_BYTE;
          p2_buf_r[g] <= `APMC_RST_BYTE;
          pdctl_r[g] <= `APMC_RST_BYTE;
          pen_r[g] <= `APMC_RST_BYTE;
        end
        else if (wr_stb && ch_wr[g] && page == APMC_PG_MASTER)
        begin
          unique case (addr)
            `APMC_OFF_P1_CORE: p1_core_r[g] <= wdata;
            `APMC_OFF_P1_BUF: p1_buf_r[g] <= {wdata[7:4], 4'h0};
            `APMC_OFF_P2_CORE: p2_core_r[g] <= wdata;
            `APMC_OFF_P2_BUF: p2_buf_r[g] <= {wdata[7:4], 4'h0};
            `APMC_OFF_PDCTL: pdctl_r[g] <= {wdata[7:5], 5'h00};
            `APMC_OFF_PEN: pen_r[g] <= wdata;
            default: ;
          endcase
        end
      end
    end
  endgenerate

  // readback follows the channel a split write would reach
  always_comb
  begin
    rd_nxt = `APMC_RST_BYTE;
    if (addr == `APMC_OFF_SPLIT)
      rd_nxt = split_r;
    else if (addr == `APMC_OFF_PAGE)
      rd_nxt = page_r;
    else if (page == APMC_PG_MASTER)
    begin
      unique case (addr)
        `APMC_OFF_P1_CORE: rd_nxt = p1_core_r[sel_b];
        `APMC_OFF_P1_BUF: rd_nxt = p1_buf_r[sel_b];
        `APMC_OFF_P2_CORE: rd_nxt = p2_core_r[sel_b];
        `APMC_OFF_P2_BUF: rd_nxt = p2_buf_r[sel_b];
        `APMC_OFF_PDCTL: rd_nxt = pdctl_r[sel_b];
        `APMC_OFF_PEN: rd_nxt = pen_r[sel_b];
        default: rd_nxt = `APMC_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rdata_r <= `APMC_RST_BYTE;
    else if (rd_stb)
      rdata_r <= rd_nxt;
    else
      rdata_r <= `APMC_RST_BYTE;
  end
  assign rdata = rdata_r;

  // active profile per channel, gated by the enable bit
  apmc_byte_t core_a_sel;
  apmc_byte_t core_b_sel;
  apmc_byte_t buf_a_sel;
  apmc_byte_t buf_b_sel;
  logic en_a;
  logic en_b;
  logic ill_a;
  logic ill_b;
  always_comb
  begin
    core_a_sel = pdctl_r[0][`APMC_BIT_CHOICE] ? p2_core_r[0] : p1_core_r[0];
    core_b_sel = pdctl_r[1][`APMC_BIT_CHOICE] ? p2_core_r[1] : p1_core_r[1];
    buf_a_sel = pdctl_r[0][`APMC_BIT_CHOICE] ? p2_buf_r[0] : p1_buf_r[0];
    buf_b_sel = pdctl_r[1][`APMC_BIT_CHOICE] ? p2_buf_r[1] : p1_buf_r[1];
  end
  assign en_a = pen_r[0][`APMC_BIT_PEN];
  assign en_b = pen_r[1][`APMC_BIT_PEN];
  // upper nibble steers channel A, lower nibble channel B
  assign core_sleep_channel_a = en_a ? core_a_sel[7:4] : 4'h0;
  assign core_sleep_channel_b = en_b ? core_b_sel[3:0] : 4'h0;

  apmc_buf_decode u_buf_a (
    .code(buf_a_sel[`APMC_BUFA_HI:`APMC_BUFA_LO]),
    .active(en_a),
    .buf_sleep(buffer_sleep_channel_a),
    .core_undriven(core_undriven_a),
    .code_illegal(ill_a)
  );
  apmc_buf_decode u_buf_b (
    .code(buf_b_sel[`APMC_BUFB_HI:`APMC_BUFB_LO]),
    .active(en_b),
    .buf_sleep(buffer_sleep_channel_b),
    .core_undriven(core_undriven_b),
    .code_illegal(ill_b)
  );
  // flags software using a do-not-use buffer code
  assign buf_code_illegal = ill_a | ill_b;

  property p_split_write;
    @(posedge mclk) disable iff (rst)
    (wr_stb && addr == `APMC_OFF_P1_CORE && page == APMC_PG_MASTER
      && !split_r[0]) |=> (p1_core_r[0] == $past(wdata)
      && p1_core_r[1] == $past(wdata));
  endproperty
  a_split_write: assert property (p_split_write)
    else $error("broadcast write missed a channel");

  property p_target_only;
    @(posedge mclk) disable iff (rst)
    (wr_stb && addr == `APMC_OFF_P2_CORE && page == APMC_PG_MASTER
      && split_r[0] && channel_target_select)
      |=> $stable(p2_core_r[0]);
  endproperty
  a_target_only: assert property (p_target_only)
    else $error("split write reached channel A");

  property p_page_gate;
    @(posedge mclk) disable iff (rst)
    (wr_stb && page_r != `APMC_PAGE_MASTER && addr != `APMC_OFF_SPLIT
      && addr != `APMC_OFF_PAGE) |=> $stable(p1_buf_r[0]);
  endproperty
  a_page_gate: assert property (p_page_gate)
    else $error("master register written off master page");

  property p_p1_store;
    @(posedge mclk) disable iff (rst)
    (wr_stb && addr == `APMC_OFF_P1_BUF && page == APMC_PG_MASTER && ch_wr[0])
      |=> p1_buf_r[0] == {$past(wdata[7:4]), 4'h0};
  endproperty
  a_p1_store: assert property (p_p1_store)
    else $error("profile one buffer not stored");

  property p_p2_read;
    @(posedge mclk) disable iff (rst)
    (rd_stb && addr == `APMC_OFF_P2_BUF && page == APMC_PG_MASTER)
      |=> rdata == $past(p2_buf_r[sel_b]);
  endproperty
  a_p2_read: assert property (p_p2_read)
    else $error("profile two readback wrong");

  property p_choice;
    @(posedge mclk) disable iff (rst)
    (en_a && pdctl_r[0][5]) |-> core_sleep_channel_a == p2_core_r[0][7:4];
  endproperty
  a_choice: assert property (p_choice)
    else $error("profile two not applied");

  property p_enable;
    @(posedge mclk) disable iff (rst)
    !en_b |-> (core_sleep_channel_b == 4'h0
      && buffer_sleep_channel_b == 2'b00);
  endproperty
  a_enable: assert property (p_enable)
    else $error("sleep applied while disabled");

  property p_nibble;
    @(posedge mclk) disable iff (rst)
    (en_b && !pdctl_r[1][5]) |-> core_sleep_channel_b == p1_core_r[1][3:0];
  endproperty
  a_nibble: assert property (p_nibble)
    else $error("channel B nibble wrong");

  property p_buf_core;
    @(posedge mclk) disable iff (rst)
    (buffer_sleep_channel_a == `APMC_BUF_OFF) |-> core_undriven_a == 4'hf;
  endproperty
  a_buf_core: assert property (p_buf_core)
    else $error("buffer sleep left cores driven");

  property p_split_store;
    @(posedge mclk) disable iff (rst)
    (wr_stb && addr == `APMC_OFF_SPLIT)
      |=> split_r == {7'h00, $past(wdata[`APMC_BIT_SPLIT])};
  endproperty
  a_split_store: assert property (p_split_store)
    else $error("split control not stored");

  property p_page_store;
    @(posedge mclk) disable iff (rst)
    (wr_stb && addr == `APMC_OFF_PAGE)
      |=> page_r == $past(wdata);
  endproperty
  a_page_store: assert property (p_page_store)
    else $error("page pointer not stored");

  property p_off_page_read;
    @(posedge mclk) disable iff (rst)
    (rd_stb && page != APMC_PG_MASTER && addr != `APMC_OFF_SPLIT
      && addr != `APMC_OFF_PAGE) |=> rdata == `APMC_RST_BYTE;
  endproperty
  a_off_page_read: assert property (p_off_page_read)
    else $error("master register readable off master page");

  property p_p2_store;
    @(posedge mclk) disable iff (rst)
    (wr_stb && addr == `APMC_OFF_P2_CORE && page == APMC_PG_MASTER
      && ch_wr[1]) |=> p2_core_r[1] == $past(wdata);
  endproperty
  a_p2_store: assert property (p_p2_store)
    else $error("profile two core byte not stored");

  property p_choice_store;
    @(posedge mclk) disable iff (rst)
    (wr_stb && addr == `APMC_OFF_PDCTL && page == APMC_PG_MASTER
      && ch_wr[0]) |=> pdctl_r[0][`APMC_BIT_CHOICE]
      == $past(wdata[`APMC_BIT_CHOICE]);
  endproperty
  a_choice_store: assert property (p_choice_store)
    else $error("profile choice bit not stored");

  property p_enable_store;
    @(posedge mclk) disable iff (rst)
    (wr_stb && addr == `APMC_OFF_PEN && page == APMC_PG_MASTER
      && ch_wr[1]) |=> pen_r[1][`APMC_BIT_PEN]
      == $past(wdata[`APMC_BIT_PEN]);
  endproperty
  a_enable_store: assert property (p_enable_store)
    else $error("profile enable bit not stored");

  property p_nibble_a;
    @(posedge mclk) disable iff (rst)
    (en_a && !pdctl_r[0][`APMC_BIT_CHOICE])
      |-> core_sleep_channel_a == p1_core_r[0][7:4];
  endproperty
  a_nibble_a: assert property (p_nibble_a)
    else $error("channel A profile one nibble wrong");

  property p_choice_b;
    @(posedge mclk) disable iff (rst)
    (en_b && pdctl_r[1][`APMC_BIT_CHOICE])
      |-> core_sleep_channel_b == p2_core_r[1][3:0];
  endproperty
  a_choice_b: assert property (p_choice_b)
    else $error("channel B profile two not applied");

  property p_buf_core_b;
    @(posedge mclk) disable iff (rst)
    (buffer_sleep_channel_b == `APMC_BUF_OFF) |-> core_undriven_b == 4'hf;
  endproperty
  a_buf_core_b: assert property (p_buf_core_b)
    else $error("channel B buffer sleep left cores driven");

  // read data only stands in the cycle after the strobe
  property p_read_idle;
    @(posedge mclk) disable iff (rst)
    !rd_stb |=> rdata == `APMC_RST_BYTE;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data outside its cycle");

  c_split: cover property (@(posedge mclk) disable iff (rst)
    wr_stb && split_r[0]);
  c_prof2: cover property (@(posedge mclk) disable iff (rst)
    en_a && pdctl_r[0][5] && core_sleep_channel_a != 4'h0);
  c_bufoff: cover property (@(posedge mclk) disable iff (rst)
    buffer_sleep_channel_b == `APMC_BUF_OFF);
  c_conv_page: cover property (@(posedge mclk) disable iff (rst)
    wr_stb && page == APMC_PG_CONV);
  c_bad_code: cover property (@(posedge mclk) disable iff (rst)
    buf_code_illegal);
endmodule

/* File: tb/tb_apmc_regs.sv */
// self-checking bench for the power mask register bank
`timescale 1ns/1ps
module tb_apmc_regs;
  logic mclk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, tgt = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [3:0] csa, csb, cua, cub;
  logic [1:0] bsa, bsb;
  logic illg, wa, wb;
  logic [7:0] ma [0:255];
  logic [7:0] mb [0:255];
  logic [7:0] page, split, v;
  integer err_count = 0, tests_run = 0, seed = 32'h31421d9f, i;
  always #12.5 mclk = ~mclk;
  apmc_regs uut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .channel_target_select(tgt),
    .rdata(rdata), .core_sleep_channel_a(csa), .core_sleep_channel_b(csb),
    .buffer_sleep_channel_a(bsa), .buffer_sleep_channel_b(bsb),
    .core_undriven_a(cua), .core_undriven_b(cub), .buf_code_illegal(illg),
    .write_to_a(wa), .write_to_b(wb));
  task close_out;
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // reserved bits are stored as zero, so the model drops them too
  function automatic logic [7:0] keep(input logic [7:0] a,
    input logic [7:0] d);
    case (a)
      8'h05: keep = d & 8'h01;
      8'h21, 8'h24: keep = d & 8'hf0;
      8'h26: keep = d & 8'he0;
      default: keep = d;
    endcase
  endfunction
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    #1;
    chk({6'h00, wa, wb}, {6'h00, !split[0] || !tgt, !split[0] || tgt});
    if (a == 8'h05)
      split = keep(a, d);
    if (a == 8'h11)
      page = d;
    if (page == 8'h80 && a inside {8'h20, 8'h21, 8'h23, 8'h24, 8'h26, 8'h55})
    begin
      if (!split[0] || !tgt)
        ma[a] = keep(a, d);
      if (!split[0] || tgt)
        mb[a] = keep(a, d);
    end
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    logic [7:0] e;
    e = (split[0] && tgt) ? mb[a] : ma[a];
    if (a == 8'h05)
      e = split;
    else if (a == 8'h11)
      e = page;
    else if (page != 8'h80)
      e = 8'h00;
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // each channel follows its own copy of the profile choice
  task chk_out;
    logic [7:0] ca, cb, ba, bb, u;
    ca = ma[8'h26][5] ? ma[8'h23] : ma[8'h20];
    cb = mb[8'h26][5] ? mb[8'h23] : mb[8'h20];
    ba = ma[8'h26][5] ? ma[8'h24] : ma[8'h21];
    bb = mb[8'h26][5] ? mb[8'h24] : mb[8'h21];
    #1;
    // the code check looks at the chosen field even while disabled
    chk({7'h00, illg}, {7'h00, (ba[5] ^ ba[4]) || (bb[7] ^ bb[6])});
    if (!ma[8'h55][0])
    begin
      ca = 8'h00;
      ba = 8'h00;
    end
    if (!mb[8'h55][0])
    begin
      cb = 8'h00;
      bb = 8'h00;
    end
    u = {{2{ba[5]}}, {2{ba[4]}}, {2{bb[7]}}, {2{bb[6]}}};
    chk({csa, csb}, {ca[7:4], cb[3:0]});
    chk({2'b00, bsa, 2'b00, bsb}, {2'b00, ba[5:4], 2'b00, bb[7:6]});
    chk({cua, cub}, u);
  endtask
  task do_reset;
    @(posedge mclk);
    rst <= 1'b1;
    for (i = 0; i < 256; i++)
    begin
      ma[i] = 8'h00;
      mb[i] = 8'h00;
    end
    page = 8'h00;
    split = 8'h00;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
  endtask
  initial
  begin
    #(25 * 20000);
    err_count++;
    close_out;
  end
  initial
  begin
    do_reset;
    chk_out;
    rd(8'h05);
    wr(8'h20, 8'hff);
    wr(8'h11, 8'h0f);
    wr(8'h20, 8'hff);
    rd(8'h20);
    wr(8'h11, 8'h80);
    rd(8'h20);
    rd(8'h40);
    wr(8'h55, 8'h01);
    for (i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 8'h0f : (i == 1) ? 8'hf0 : 8'hff;
      wr(8'h20, v);
      chk_out;
    end
    wr(8'h21, 8'h10);
    chk_out;
    wr(8'h21, 8'hc0);
    chk_out;
    rd(8'h21);
    wr(8'h23, 8'h5a);
    wr(8'h24, 8'h30);
    chk_out;
    wr(8'h26, 8'h20);
    chk_out;
    rd(8'h26);
    wr(8'h55, 8'h00);
    chk_out;
    wr(8'h55, 8'h01);
    // random split, target, page and profile contents, one idle cycle between strobes
    for (i = 0; i < 30; i++)
    begin
      v = 8'($random(seed));
      @(posedge mclk);
      tgt <= v[7];
      wr(8'h05, 8'h00);
      wr(8'h11, v[6] ? 8'h0f : 8'h80);
      wr(8'h26, {2'b00, v[5], 5'h00});
      wr(8'h05, {7'h00, v[0]});
      wr(v[1] ? 8'h23 : 8'h20, 8'($random(seed)));
      wr(v[2] ? 8'h24 : 8'h21, {v[3], v[3], v[4], v[4], 4'h0});
      chk_out;
      rd(v[1] ? 8'h23 : 8'h20);
      rd(8'($random(seed)));
    end
    do_reset;
    chk_out;
    rd(8'h11);
    close_out;
  end
endmodule
